/* rs485_auto_direction_uart.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Character queue in flip-flops
// ----------------------------------------
module char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata,
	output logic                  empty,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp, rp;
	logic [AW:0]      cnt;

	assign rdata = mem[rp];
	assign empty = (cnt == '0);
	assign full  = (cnt == (AW+1)'(DEPTH));

	// Pointers and fill count
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push && !full) wp <= wp + AW'(1);
			if (pop && !empty) rp <= rp + AW'(1);
			cnt <= cnt + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
		end
	end

	// Storage
	always_ff @(posedge ref_clk) begin
		if (push && !full) mem[wp] <= wdata;
	end
endmodule

// Overview of operation
// - Driver enable rises by itself once a character waits to be sent.
// - Driver stays on one extra character time after the last character.
// - Receiver is off while the driver is on, on again together.
// - The hold time follows the programmed divisor and frame format.
// - A readable status register shows which ports request service.
// - All port requests may share one line; each port still routes itself.
// - Each port decodes eight addresses at its own base, on any 8-aligned boundary in 000 to 3FF.
// - Each port routes to one of lines 2-7, 10-12, 14 or 15.
// - Baud clock selectable between x1 and x4, x4 four times faster.
// - Line status at base plus 5 reads 60 hex when idle.
module rs485_auto_direction_uart
	import rs485_uart_pkg::*;
#(
	parameter int NP = NUM_PORTS
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// Host I/O bus
	input  wire logic [9:0]          io_addr,
	input  wire logic                io_rd,
	input  wire logic                io_wr,
	input  wire logic [7:0]          io_wdata,
	output logic      [7:0]          io_rdata,
	output logic      [15:0]         host_irq,
	// Board settings
	input  wire logic [NP-1:0][9:0]  base_addr,
	input  wire logic [9:0]          status_addr,
	input  wire logic [NP-1:0][3:0]  irq_line,
	input  wire logic                clock_x4,
	// RS485 lines
	input  wire logic [NP-1:0]       rxd,
	output line_t     [NP-1:0]       line
);
	logic [NP-1:0] hit, pend;
	logic [7:0]    port_rd [NP];
	logic [7:0]    next_rdata;
	logic [15:0]   next_irq;
	logic [2:0]    ofs;

	assign ofs = io_addr[2:0];

	for (genvar p = 0; p < NP; p++) begin : g_port
		lcr_t        lcr;
		logic [15:0] div;
		logic [1:0]  ier;
		logic [7:0]  scr, tx_data, tx_tk, rx_tk, rx_char;
		logic        oe, pe, fe, tick, wr_here, rd_here;
		logic        tx_push, tx_pop, tx_empty, tx_full;
		logic        rx_push, rx_pop, rx_empty, rx_full;
		logic [17:0] pre;
		logic [9:0]  rx_word, rx_head;
		logic [11:0] shreg;
		logic [10:0] rx_bits;
		tx_state_t   tx_state;
		rx_state_t   rx_state;

		assign hit[p]  = (io_addr[9:3] == base_addr[p][9:3]);
		assign wr_here = io_wr && hit[p];
		assign rd_here = io_rd && hit[p];
		assign tx_push = wr_here && ofs == OFS_DATA && !lcr.dlab;
		assign rx_pop  = rd_here && ofs == OFS_DATA && !lcr.dlab;
		assign pend[p] = (ier[0] && !rx_empty) || (ier[1] && tx_empty);
		// Programmable settings
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				lcr <= lcr_t'(LCR_RESET);
				div <= DIV_RESET;
				ier <= 2'h0;
				scr <= 8'h00;
			end else if (wr_here) begin
				unique case (ofs)
					OFS_DATA: if (lcr.dlab) div[7:0] <= io_wdata; 
					OFS_IER: begin
						if (lcr.dlab) div[15:8] <= io_wdata;
						else ier <= io_wdata[1:0];
					end
					OFS_LCR: lcr <= lcr_t'(io_wdata);
					OFS_SCR: scr <= io_wdata;
					default: ;
				endcase
			end
		end
		// x1 setting divides four times further than x4
		// tick rate follows the programmed divisor
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				pre  <= '0;
				tick <= 1'b0;
			end else begin
				tick <= (pre == '0);
				if (pre == '0) pre <= (clock_x4 ? {2'h0, div} : {div, 2'h0}) - 18'h1;
				else pre <= pre - 18'h1;
			end
		end
		char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx (
			.ref_clk(ref_clk), .rst(rst), .push(tx_push), .pop(tx_pop),
			.wdata(io_wdata), .rdata(tx_data), .empty(tx_empty), .full(tx_full)
		);
		char_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rx (
			.ref_clk(ref_clk), .rst(rst), .push(rx_push), .pop(rx_pop),
			.wdata(rx_word), .rdata(rx_head), .empty(rx_empty), .full(rx_full)
		);
		// Next character taken at a tick once the frame ends
		assign tx_pop = tick && !tx_empty
			&& (tx_state != TX_SHIFT || tx_tk == frame_ticks(lcr) - 8'h1);
		// Transmit sequence
		// hold one character time after the last frame ends
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				tx_state <= TX_IDLE;
				shreg    <= 12'hFFF;
				tx_tk    <= 8'h00;
			end else if (tx_pop) begin
				tx_state <= TX_SHIFT;
				shreg    <= frame_word(lcr, tx_data);
				tx_tk    <= 8'h00;
			end else if (tick) begin
				unique case (tx_state)
					TX_IDLE: tx_tk <= 8'h00;
					TX_SHIFT: begin
						tx_tk <= tx_tk + 8'h1;
						if (tx_tk[3:0] == 4'hF) shreg <= {1'b1, shreg[11:1]};
						if (tx_tk == frame_ticks(lcr) - 8'h1) begin
							tx_state <= TX_HOLD;
							tx_tk    <= 8'h00;
						end
					end
					TX_HOLD: begin
						tx_tk <= tx_tk + 8'h1;
						if (tx_tk == frame_ticks(lcr) - 8'h1) tx_state <= TX_IDLE;
					end
					default: tx_state <= TX_IDLE;
				endcase
			end
		end
		// Line pins
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				line[p] <= '{txd: 1'b1, drv_en: 1'b0, rcv_en_n: 1'b0};
			end else begin
				line[p].txd <= shreg[0] && !lcr.brk;
				// enable as soon as data waits
				line[p].drv_en <= tx_state != TX_IDLE || !tx_empty;
				line[p].rcv_en_n <= tx_state != TX_IDLE || !tx_empty;
			end
		end
		// Receive sequence, idle while the port drives
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				rx_state <= RX_IDLE;
				rx_tk    <= 8'h00;
				rx_bits  <= '0;
				rx_push  <= 1'b0;
				rx_word  <= '0;
			end else begin
				rx_push <= 1'b0;
				if (line[p].rcv_en_n) begin
					rx_state <= RX_IDLE;
				end else if (tick) begin
					unique case (rx_state)
						RX_IDLE: begin
							rx_tk <= 8'h00;
							if (!rxd[p]) rx_state <= RX_BITS;
						end
						RX_BITS: begin
							rx_tk <= rx_tk + 8'h1;
							if (rx_tk[3:0] == HALF_BIT[3:0]) begin
								rx_bits[rx_tk[7:4]] <= rxd[p];
								if (rx_tk[7:4] == 4'h0 && rxd[p]) rx_state <= RX_IDLE;
								if (rx_tk[7:4] == frame_bits(lcr)) begin
									rx_state <= RX_IDLE;
									rx_push  <= 1'b1;
									rx_word  <= {!rxd[p], lcr.par_en
										&& rx_bits[frame_bits(lcr) - 4'h1]
										!= par_bit(lcr, rx_char), rx_char};
								end
							end
						end
						default: rx_state <= RX_IDLE;
					endcase
				end
			end
		end
		// Received data bits, upper unused bits cleared
		assign rx_char = rx_bits[8:1] & (8'hFF >> (2'h3 - lcr.wlen));
		// Error flags; a new error wins over the clearing read
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				oe <= 1'b0;
				pe <= 1'b0;
				fe <= 1'b0;
			end else begin
				oe <= (rx_push && rx_full) || (oe && !(rd_here && ofs == OFS_LSR));
				pe <= (rx_pop && rx_head[8]) || (pe && !(rd_here && ofs == OFS_LSR));
				fe <= (rx_pop && rx_head[9]) || (fe && !(rd_here && ofs == OFS_LSR));
			end
		end
		// Read view of this port
		// idle line status is 60 hex
		always_comb begin
			unique case (ofs)
				OFS_DATA: port_rd[p] = lcr.dlab ? div[7:0] : rx_head[7:0];
				OFS_IER:  port_rd[p] = lcr.dlab ? div[15:8] : {6'h00, ier};
				OFS_IIR:  port_rd[p] = (ier[0] && !rx_empty) ? IIR_RX
					: (ier[1] && tx_empty) ? IIR_TX : IIR_NONE;
				OFS_LCR:  port_rd[p] = lcr;
				OFS_LSR:  port_rd[p] = {1'b0, tx_empty && tx_state == TX_IDLE,
					tx_empty, 1'b0, fe, pe, oe, !rx_empty};
				OFS_SCR:  port_rd[p] = scr;
				default:  port_rd[p] = 8'h00;
			endcase
		end
	end

	// Read data and shared request lines
	always_comb begin
		next_rdata = 8'h00;
		next_irq   = 16'h0000;
		for (int p = 0; p < NP; p++) begin
			if (hit[p]) next_rdata = next_rdata | port_rd[p];
			// only allowed host lines, one per port
			// requests routed to one line are merged
			if (pend[p] && IRQ_LINE_OK[irq_line[p]]) next_irq[irq_line[p]] = 1'b1;
		end
		// shared status, one bit per port
		if (io_addr == status_addr) next_rdata = 8'(pend);
	end

	// Registered host outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
			host_irq <= 16'h0000;
		end else begin
			if (io_rd) io_rdata <= next_rdata;
			host_irq <= next_irq;
		end
	end
endmodule

/* rs485_uart_pkg.sv */
package rs485_uart_pkg;

	// ----------------------------------------
	// Sizes and register offsets
	// ----------------------------------------
	localparam int       NUM_PORTS  = 8;
	localparam int       FIFO_DEPTH = 16;
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IER  = 3'h1;
	localparam logic [2:0] OFS_IIR  = 3'h2;
	localparam logic [2:0] OFS_LCR  = 3'h3;
	localparam logic [2:0] OFS_LSR  = 3'h5;
	localparam logic [2:0] OFS_SCR  = 3'h7;

	// Reset, idle and interrupt identification values
	localparam logic [7:0]  LSR_IDLE    = 8'h60;
	localparam logic [7:0]  LCR_RESET   = 8'h00;
	localparam logic [15:0] DIV_RESET   = 16'h0001;
	localparam logic [7:0]  IIR_NONE    = 8'hC1;
	localparam logic [7:0]  IIR_RX      = 8'hC4;
	localparam logic [7:0]  IIR_TX      = 8'hC2;
	// Host lines 2-7, 10-12, 14, 15 may carry a port request
	localparam logic [15:0] IRQ_LINE_OK = 16'hDCFC;

	// Timing in baud ticks (sixteen per bit)
	localparam logic [7:0] HALF_BIT    = 8'h08;
	localparam logic [7:0] STOP_ONE    = 8'h10;
	localparam logic [7:0] STOP_HALF3  = 8'h18;
	localparam logic [7:0] STOP_TWO    = 8'h20;
	localparam logic [1:0] X1_SCALE    = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       dlab;
		logic       brk;
		logic       stick;
		logic       even;
		logic       par_en;
		logic       stop2;
		logic [1:0] wlen;
	} lcr_t;

	typedef struct packed {
		logic txd;
		logic drv_en;
		logic rcv_en_n;
	} line_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_HOLD  = 2'b10
	} tx_state_t;

	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_BITS = 1'b1
	} rx_state_t;

	// Bits on the wire before the stop bits
	function automatic logic [3:0] frame_bits(input lcr_t l);
		frame_bits = 4'h6 + {2'h0, l.wlen} + {3'h0, l.par_en};
	endfunction

	// Ticks in one whole character
	function automatic logic [7:0] frame_ticks(input lcr_t l);
		logic [7:0] stop;
		stop = !l.stop2 ? STOP_ONE : (l.wlen == 2'h0) ? STOP_HALF3 : STOP_TWO;
		frame_ticks = {frame_bits(l), 4'h0} + stop;
	endfunction

	// Parity bit for a character
	function automatic logic par_bit(input lcr_t l, input logic [7:0] d);
		logic [7:0] m;
		m = d & (8'hFF >> (2'h3 - l.wlen));
		par_bit = l.stick ? ~l.even : (l.even ? ^m : ~^m);
	endfunction

	// Start, data and parity, ones beyond
	function automatic logic [11:0] frame_word(input lcr_t l, input logic [7:0] d);
		logic [3:0] nb;
		nb = 4'h5 + {2'h0, l.wlen};
		frame_word = 12'hFFF;
		frame_word[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nb)) begin
				frame_word[i + 1] = d[i];
			end
		end
		if (l.par_en) begin
			frame_word[nb + 4'h1] = par_bit(l, d);
		end
	endfunction

endpackage

/* rs485_uart_sva.sv */
`timescale 1ns/1ps
module rs485_uart_chk
	import rs485_uart_pkg::*;
#(
	parameter int NP = NUM_PORTS
) (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rst,
	// Host bus
	input wire logic [9:0]          io_addr,
	input wire logic                io_rd,
	input wire logic                io_wr,
	input wire logic [7:0]          io_wdata,
	input wire logic [7:0]          io_rdata,
	input wire logic [15:0]         host_irq,
	// Straps and lines
	input wire logic [NP-1:0][9:0]  base_addr,
	input wire logic [9:0]          status_addr,
	input wire line_t [NP-1:0]      line
);
	logic          dlab0;
	logic          hit;
	logic [NP-1:0] drv;
	logic [NP-1:0] rcv;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Decode hit and per-port enable vectors
	always_comb begin
		hit = (io_addr == status_addr);
		for (int p = 0; p < NP; p++) begin
			hit = hit | (io_addr[9:3] == base_addr[p][9:3]);
			drv[p] = line[p].drv_en;
			rcv[p] = line[p].rcv_en_n;
		end
	end

	// Divisor access bit of port 0
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dlab0 <= 1'b0;
		end else if (io_wr && io_addr == {base_addr[0][9:3], OFS_LCR}) begin
			dlab0 <= io_wdata[7];
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	chk_rcv_tracks_drv: assert property (drv == rcv)
		else $error("receiver enable differs from driver enable");
	chk_drv_on_write: assert property (io_wr && !dlab0 &&
		io_addr == {base_addr[0][9:3], OFS_DATA} |-> ##2 drv[0])
		else $error("driver not enabled after data write");
	chk_start_soon: assert property ($rose(drv[0]) |-> ##[1:40] !line[0].txd)
		else $error("no start bit after driver enable");
	chk_txd_idle: assert property (!drv[0] |-> line[0].txd)
		else $error("txd not idle while driver off");
	chk_hold_min: assert property ($rose(drv[0]) |-> drv[0] [*8])
		else $error("driver enable too short");
	chk_irq_legal: assert property ((host_irq & ~IRQ_LINE_OK) == 16'h0000)
		else $error("request on a host line not allowed");
	chk_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data changed without a read");
	chk_unmapped_zero: assert property (io_rd && !hit |=> io_rdata == 8'h00)
		else $error("unmapped read returned nonzero");

	cov_tx: cover property ($rose(drv[0]));
	cov_irq: cover property (host_irq != 16'h0000);
	cov_unmapped: cover property (io_rd && !hit);
endmodule

bind rs485_auto_direction_uart rs485_uart_chk #(.NP(NP)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd),
	.io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.host_irq(host_irq), .base_addr(base_addr),
	.status_addr(status_addr), .line(line)
);

/* rs485_node.sv */
`timescale 1ns/1ps
module rs485_node
	import rs485_uart_pkg::*;
(
	// Clock and pair
	input wire logic  ref_clk,
	input wire line_t tx_line,
	input wire logic [31:0] bit_cyc,
	output logic      rxd,
	output logic [7:0] got
);
	// Biased pair idles at mark
	initial rxd = 1'b1;

	// Capture device character mid-bit, LSB first
	always begin
		@(negedge tx_line.txd);
		if (tx_line.drv_en) begin
			repeat (bit_cyc / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cyc) @(posedge ref_clk);
				got[i] = tx_line.txd;
			end
		end
	end

	// Send one 8N1 character onto the pair
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			rxd = f[i];
			repeat (bit_cyc - 1) @(negedge ref_clk);
		end
	endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
	import rs485_uart_pkg::*;
	logic                ref_clk = 1'b0;
	logic                rst = 1'b1;
	logic [9:0]          io_addr = 10'h000;
	logic                io_rd = 1'b0;
	logic                io_wr = 1'b0;
	logic [7:0]          io_wdata = 8'h00;
	logic [7:0]          io_rdata;
	logic [15:0]         host_irq;
	logic [7:0][9:0]     base_addr;
	logic [9:0]          status_addr = 10'h3F0;
	logic [7:0][3:0]     irq_line;
	logic                clock_x4 = 1'b0;
	logic                node_rxd;
	logic [7:0]          got;
	line_t [7:0]         line;
	int                  bit_cyc = 64;
	int                  fail_count = 0;
	int                  n_tests = 0;

	always #4 ref_clk = ~ref_clk;

	rs485_auto_direction_uart #(.NP(8)) uut (
		.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.host_irq(host_irq), .base_addr(base_addr), .status_addr(status_addr),
		.irq_line(irq_line), .clock_x4(clock_x4), .rxd({7'h7F, node_rxd}),
		.line(line)
	);
	rs485_node node (
		.ref_clk(ref_clk), .tx_line(line[0]), .bit_cyc(bit_cyc),
		.rxd(node_rxd), .got(got)
	);

	task automatic summarize();
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic cmp_near(input string s, input int e, input int g);
		n_tests++;
		if (g < e - 8 || g > e + 8) begin
			fail_count++;
			$display("CHECK FAILED %s exp %0d got %0d", s, e, g);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge ref_clk);
		io_wr = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge ref_clk);
		io_rd = 1'b0;
		d = io_rdata;
	endtask

	task automatic wait_drv(input logic v, output int c);
		c = 0;
		while (line[0].drv_en !== v && c < 20000) begin
			@(negedge ref_clk);
			c++;
		end
		if (c >= 20000) begin
			fail_count++;
			summarize();
		end
	endtask

	// Frame format, divisor and rate of port 0
	task automatic cfg(input logic [7:0] lcr, input logic [7:0] d, input logic x4);
		clock_x4 = x4;
		bit_cyc = x4 ? 16 * int'(d) : 64 * int'(d);
		wr(10'h303, {1'b1, lcr[6:0]});
		wr(10'h300, d);
		wr(10'h301, 8'h00);
		wr(10'h303, lcr);
	endtask

	// Queue n chars, time the driver enable window
	task automatic test_hold(input logic [7:0] lcr, input logic [7:0] d,
		input logic x4, input int n, input int exp);
		int c;
		cfg(lcr, d, x4);
		repeat (n) wr(10'h300, 8'h5A);
		wait_drv(1'b1, c);
		cmp("rcv_en_n on", 16'h0001, {15'h0, line[0].rcv_en_n});
		wait_drv(1'b0, c);
		cmp_near("drv_en cycles", exp, c);
		cmp("rcv_en_n off", 16'h0000, {15'h0, line[0].rcv_en_n});
	endtask

	// Idle status of every port and an unmapped read
	task automatic test_idle();
		logic [7:0] v;
		for (int p = 0; p < 8; p++) begin
			rd(base_addr[p] + 10'h005, v);
			cmp("idle lsr", 16'h0060, {8'h00, v});
		end
		rd(10'h100, v);
		cmp("unmapped", 16'h0000, {8'h00, v});
		wr(10'h307, 8'hC3);
		rd(10'h307, v);
		cmp("scratch", 16'h00C3, {8'h00, v});
	endtask

	// Receive, shared status and line routing
	task automatic test_rx();
		logic [7:0] v;
		cfg(8'h03, 8'h01, 1'b0);
		irq_line[0] = 4'd8;
		wr(10'h301, 8'h01);
		node.send(8'hA5);
		repeat (8) @(negedge ref_clk);
		cmp("irq on bad line", 16'h0000, host_irq);
		rd(status_addr, v);
		cmp("shared status", 16'h0001, {8'h00, v});
		rd(10'h305, v);
		cmp("lsr ready", {8'h00, LSR_IDLE | 8'h01}, {8'h00, v});
		rd(10'h302, v);
		cmp("iir rx", {8'h00, IIR_RX}, {8'h00, v});
		irq_line[0] = 4'd5;
		repeat (3) @(negedge ref_clk);
		cmp("shared irq", 16'h0020, host_irq);
		rd(10'h300, v);
		cmp("rx data", 16'h00A5, {8'h00, v});
		repeat (3) @(negedge ref_clk);
		cmp("irq cleared", 16'h0000, host_irq);
		rd(10'h302, v);
		cmp("iir none", {8'h00, IIR_NONE}, {8'h00, v});
	endtask

	initial begin
		for (int p = 0; p < 8; p++) begin
			base_addr[p] = 10'h300 + 10'(8 * p);
			irq_line[p] = 4'd5;
		end
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		test_idle();
		test_hold(8'h03, 8'h01, 1'b0, 2, 1920);
		cmp("tx byte", 16'h005A, {8'h00, got});
		test_hold(8'h03, 8'h01, 1'b1, 1, 320);
		test_hold(8'h04, 8'h01, 1'b1, 1, 240);
		test_hold(8'h09, 8'h01, 1'b1, 1, 288);
		test_hold(8'h1E, 8'h02, 1'b1, 1, 704);
		test_rx();
		summarize();
	end
endmodule
